// File: design/vetcr_regs.sv
`timescale 1ns/1ps
module vetcr_regs (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [vetcr_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [vetcr_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [vetcr_pkg::DATA_W-1:0] reg_rdata,
  input wire logic trig_go,
  input wire logic [vetcr_pkg::FRAC_W-1:0] trig_angle,
  output logic trig_busy,
  output logic trig_updated,
  output logic [vetcr_pkg::FRAC_W-1:0] prior_x_component,
  output logic [vetcr_pkg::FRAC_W-1:0] prior_y_component,
  output logic [vetcr_pkg::FRAC_W-1:0] current_x_component,
  output logic [vetcr_pkg::FRAC_W-1:0] current_y_component,
  output logic [vetcr_pkg::FRAC_W-1:0] direct_current_setpoint,
  output logic [vetcr_pkg::FRAC_W-1:0] quadrature_current_setpoint
);
  import vetcr_pkg::*;

  // ----------------------------------------
  // Address decode
  // ----------------------------------------
  function automatic logic reg_hit(input logic [7:0] addr, input logic [7:0] off);
    reg_hit = (addr == off);
  endfunction

  function automatic logic [7:0] reg_offset(input int unsigned idx);
    case (idx)
      IDX_X: reg_offset = OFF_ANGLE_X;
      IDX_Y: reg_offset = OFF_ANGLE_Y;
      IDX_PX: reg_offset = OFF_PRIOR_X;
      IDX_PY: reg_offset = OFF_PRIOR_Y;
      IDX_DSET: reg_offset = OFF_DIRECT_SET;
      default: reg_offset = OFF_QUAD_SET;
    endcase
  endfunction

  logic [15:0] reg_q [0:NUM_REGS-1];
  logic [31:0] rdata_q;
  logic updated_q;
  logic eng_done;
  logic [15:0] eng_cos;
  logic [15:0] eng_sin;
  logic [NUM_REGS-1:0] wr_hit;
  logic [NUM_REGS-1:0] rd_hit;
  logic [NUM_REGS-1:0] hw_load;
  logic [15:0] hw_val [0:NUM_REGS-1];
  logic [15:0] rd_mux;

  // ----------------------------------------
  // Sine/cosine engine
  // ----------------------------------------
  // A start while the engine runs is dropped; trig_busy tells the sequencer
  vetcr_sincos u_sincos (
    .clk(clk),
    .reset_n(reset_n),
    .start(trig_go),
    .angle(trig_angle),
    .busy(trig_busy),
    .done(eng_done),
    .cos_out(eng_cos),
    .sin_out(eng_sin)
  );

  // ----------------------------------------
  // Hardware update on task 6 completion
  // ----------------------------------------
  // Prior registers take the value held before this edge, so old and new
  // values move in the same cycle without a race
  assign hw_load[IDX_X] = eng_done;
  assign hw_load[IDX_Y] = eng_done;
  assign hw_load[IDX_PX] = eng_done;
  assign hw_load[IDX_PY] = eng_done;
  assign hw_load[IDX_DSET] = 1'b0;
  assign hw_load[IDX_QSET] = 1'b0;
  assign hw_val[IDX_X] = eng_cos;
  assign hw_val[IDX_Y] = eng_sin;
  assign hw_val[IDX_PX] = reg_q[IDX_X];
  assign hw_val[IDX_PY] = reg_q[IDX_Y];
  assign hw_val[IDX_DSET] = FRAC_RESET;
  assign hw_val[IDX_QSET] = FRAC_RESET;

  // ----------------------------------------
  // Register storage
  // ----------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < NUM_REGS; gi++) begin : g_reg
      assign wr_hit[gi] = reg_wr && reg_hit(reg_addr, reg_offset(gi));
      assign rd_hit[gi] = reg_rd && reg_hit(reg_addr, reg_offset(gi));
      // Hardware update wins over a software write in the same cycle
      always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
          reg_q[gi] <= FRAC_RESET;
        end else if (hw_load[gi]) begin
          reg_q[gi] <= hw_val[gi];
        end else if (wr_hit[gi]) begin
          reg_q[gi] <= reg_wdata[15:0];
        end
      end
    end
  endgenerate

  // ----------------------------------------
  // Read path
  // ----------------------------------------
  // Unmapped or unaligned addresses read as zero
  assign rd_mux = rd_hit[IDX_X] ? reg_q[IDX_X] :
                  rd_hit[IDX_Y] ? reg_q[IDX_Y] :
                  rd_hit[IDX_PX] ? reg_q[IDX_PX] :
                  rd_hit[IDX_PY] ? reg_q[IDX_PY] :
                  rd_hit[IDX_DSET] ? reg_q[IDX_DSET] :
                  rd_hit[IDX_QSET] ? reg_q[IDX_QSET] : FRAC_RESET;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rdata_q <= RDATA_RESET;
    end else begin
      rdata_q <= {UPPER_ZERO, rd_mux};
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      updated_q <= 1'b0;
    end else begin
      updated_q <= eng_done;
    end
  end

  // ----------------------------------------
  // Task-facing outputs
  // ----------------------------------------
  assign reg_rdata = rdata_q;
  assign trig_updated = updated_q;
  assign prior_x_component = reg_q[IDX_PX];
  assign prior_y_component = reg_q[IDX_PY];
  assign current_x_component = reg_q[IDX_X];
  assign current_y_component = reg_q[IDX_Y];
  assign direct_current_setpoint = reg_q[IDX_DSET];
  assign quadrature_current_setpoint = reg_q[IDX_QSET];

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);

  a_upper_zero: assert property (reg_rdata[31:16] == UPPER_ZERO)
    else $error("upper half of read data not zero");
  a_cos_store: assert property (eng_done |=> current_x_component == $past(eng_cos))
    else $error("cosine register missed the new result");
  a_sin_store: assert property (eng_done |=> current_y_component == $past(eng_sin))
    else $error("sine register missed the new result");
  a_trig_hold: assert property (($changed(reg_q[IDX_PX]) || $changed(reg_q[IDX_X]))
    |-> ($past(eng_done) || $past(wr_hit[IDX_PX]) || $past(wr_hit[IDX_X])))
    else $error("trigonometric register changed outside task 6 or a write");
  a_prior_x_copy: assert property (eng_done |=> prior_x_component == $past(current_x_component))
    else $error("prior cosine did not take the old cosine");
  a_prior_y_copy: assert property (eng_done |=> prior_y_component == $past(current_y_component))
    else $error("prior sine did not take the old sine");
  // Prior pair must still hold the values seen at the done edge, unless rewritten meanwhile
  a_task4_prior: assert property (eng_done ##1 (!eng_done && !wr_hit[IDX_PX] && !wr_hit[IDX_PY]) [*2] |->
    prior_x_component == $past(current_x_component, 2) && prior_y_component == $past(current_y_component, 2))
    else $error("task 4 inputs not the prior values");
  a_task7_current: assert property ((eng_done && !wr_hit[IDX_X]) ##1 !eng_done |->
    current_x_component == $past(eng_cos))
    else $error("task 7 input not the current cosine");
  a_dset_write: assert property ((wr_hit[IDX_DSET]) |=>
    direct_current_setpoint == $past(reg_wdata[15:0]))
    else $error("d-axis setpoint write lost");
  a_qset_write: assert property ((wr_hit[IDX_QSET]) |=>
    quadrature_current_setpoint == $past(reg_wdata[15:0]))
    else $error("q-axis setpoint write lost");
  a_read_value: assert property (rd_hit[IDX_PY] |=> reg_rdata == {UPPER_ZERO, $past(reg_q[IDX_PY])})
    else $error("read data not the register value one cycle later");
  a_update_pulse: assert property (eng_done |=> trig_updated ##1 !trig_updated)
    else $error("update pulse not one cycle after engine done");

  c_trig_update: cover property (trig_go && !trig_busy ##19 trig_updated);
  c_setpoint_write: cover property (wr_hit[IDX_DSET] ##1 wr_hit[IDX_QSET]);
  c_prior_read: cover property (eng_done ##1 rd_hit[IDX_PX]);
  c_write_clash: cover property (eng_done && wr_hit[IDX_X]);
endmodule

// File: design/vetcr_pkg.sv
// Behaviour
// - The cosine result sits in bits 15-0 as a signed fraction from 0x8000 to 0x7fff; bits 31-16 read zero.
// - The cosine result is computed by hardware from the current phase angle as a 16-bit signed fraction.
// - The sine result is computed the same way from the phase angle and also sits in bits 15-0.
// - Hardware changes the four trigonometric registers only when the sine/cosine task (task 6) completes.
// - On that task the old cosine moves into the prior cosine register before the new cosine is stored.
// - On that task the old sine moves into the prior sine register before the new sine is stored.
// - The input transformation (task 4) is fed the prior cosine and prior sine values.
// - The output transformation (task 7) is fed the current cosine and sine values.
// - The current-control task (task 5) reads both current targets as its setpoints.
package vetcr_pkg;

  // ----------------------------------------
  // Register map
  // ----------------------------------------
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned FRAC_W = 16;
  localparam int unsigned NUM_REGS = 6;
  localparam int unsigned IDX_X = 0;
  localparam int unsigned IDX_Y = 1;
  localparam int unsigned IDX_PX = 2;
  localparam int unsigned IDX_PY = 3;
  localparam int unsigned IDX_DSET = 4;
  localparam int unsigned IDX_QSET = 5;
  localparam logic [7:0] OFF_ANGLE_X = 8'h00;
  localparam logic [7:0] OFF_ANGLE_Y = 8'h04;
  localparam logic [7:0] OFF_PRIOR_X = 8'h08;
  localparam logic [7:0] OFF_PRIOR_Y = 8'h0c;
  localparam logic [7:0] OFF_DIRECT_SET = 8'h10;
  localparam logic [7:0] OFF_QUAD_SET = 8'h14;
  localparam logic [15:0] FRAC_RESET = 16'h0000;
  localparam logic [15:0] UPPER_ZERO = 16'h0000;
  localparam logic [31:0] RDATA_RESET = 32'h0000_0000;

  // ----------------------------------------
  // Sine/cosine engine
  // ----------------------------------------
  localparam int unsigned CORDIC_W = 20;
  localparam int unsigned ZW = 21;
  localparam logic [3:0] ITER_FIRST = 4'h0;
  localparam logic [3:0] ITER_LAST = 4'hf;
  localparam logic signed [19:0] CORDIC_GAIN_INIT = 20'sh136ea;
  localparam logic signed [19:0] ROUND_HALF = 20'sh00002;
  localparam logic signed [19:0] SAT_MAX = 20'sh07fff;
  localparam logic signed [19:0] SAT_MIN = 20'shf8000;
  localparam logic signed [19:0] CORDIC_ZERO = 20'sh00000;
  localparam logic signed [20:0] Z_ZERO = 21'sh000000;

  typedef enum logic [1:0] {
    VETCR_IDLE = 2'b00,
    VETCR_RUN = 2'b01,
    VETCR_DONE = 2'b10
  } vetcr_state_e;

endpackage

// File: design/vetcr_sincos.sv
`timescale 1ns/1ps
module vetcr_sincos (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic start,
  input wire logic [15:0] angle,
  output logic busy,
  output logic done,
  output logic [15:0] cos_out,
  output logic [15:0] sin_out
);
  import vetcr_pkg::*;

  // ----------------------------------------
  // Arctangent table, 2^20 per turn
  // ----------------------------------------
  function automatic logic [19:0] atan_lut(input logic [3:0] i);
    case (i)
      4'h0: atan_lut = 20'h20000;
      4'h1: atan_lut = 20'h12e41;
      4'h2: atan_lut = 20'h09fb4;
      4'h3: atan_lut = 20'h05111;
      4'h4: atan_lut = 20'h028b1;
      4'h5: atan_lut = 20'h0145e;
      4'h6: atan_lut = 20'h00a2f;
      4'h7: atan_lut = 20'h00518;
      4'h8: atan_lut = 20'h0028c;
      4'h9: atan_lut = 20'h00146;
      4'ha: atan_lut = 20'h000a3;
      4'hb: atan_lut = 20'h00051;
      4'hc: atan_lut = 20'h00029;
      4'hd: atan_lut = 20'h00014;
      4'he: atan_lut = 20'h0000a;
      default: atan_lut = 20'h00005;
    endcase
  endfunction

  // Rounds Q17 to Q15 and clamps, so +1.0 reads 0x7fff
  function automatic logic [15:0] sat_q15(input logic signed [19:0] v);
    logic signed [19:0] r;
    r = (v + ROUND_HALF) >>> 2;
    if (r > SAT_MAX) begin
      sat_q15 = SAT_MAX[15:0];
    end else if (r < SAT_MIN) begin
      sat_q15 = SAT_MIN[15:0];
    end else begin
      sat_q15 = r[15:0];
    end
  endfunction

  // ----------------------------------------
  // Datapath
  // ----------------------------------------
  vetcr_state_e state_q;
  logic signed [19:0] x_q;
  logic signed [19:0] y_q;
  logic signed [20:0] z_q;
  logic [1:0] quad_q;
  logic [3:0] iter_q;
  logic done_q;
  logic [15:0] cos_q;
  logic [15:0] sin_q;

  wire take_start = start && (state_q == VETCR_IDLE);
  wire rot_pos = ~z_q[20];
  wire signed [19:0] shift_x = x_q >>> iter_q;
  wire signed [19:0] shift_y = y_q >>> iter_q;
  wire signed [20:0] atan_step = {1'b0, atan_lut(iter_q)};
  wire signed [19:0] x_step = rot_pos ? x_q - shift_y : x_q + shift_y;
  wire signed [19:0] y_step = rot_pos ? y_q + shift_x : y_q - shift_x;
  wire signed [20:0] z_step = rot_pos ? z_q - atan_step : z_q + atan_step;
  // Residual angle inside one quadrant; quadrant restored afterwards
  wire signed [20:0] z_init = {3'b000, angle[13:0], 4'h0};
  wire signed [19:0] map_x = (quad_q == 2'b00) ? x_q : (quad_q == 2'b01) ? -y_q : (quad_q == 2'b10) ? -x_q : y_q;
  wire signed [19:0] map_y = (quad_q == 2'b00) ? y_q : (quad_q == 2'b01) ? x_q : (quad_q == 2'b10) ? -y_q : -x_q;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_q <= VETCR_IDLE;
      x_q <= CORDIC_ZERO;
      y_q <= CORDIC_ZERO;
      z_q <= Z_ZERO;
      quad_q <= 2'b00;
      iter_q <= ITER_FIRST;
    end else begin
      case (state_q)
        VETCR_IDLE: begin
          if (take_start) begin
            x_q <= CORDIC_GAIN_INIT;
            y_q <= CORDIC_ZERO;
            z_q <= z_init;
            quad_q <= angle[15:14];
            iter_q <= ITER_FIRST;
            state_q <= VETCR_RUN;
          end
        end
        VETCR_RUN: begin
          x_q <= x_step;
          y_q <= y_step;
          z_q <= z_step;
          iter_q <= iter_q + 4'h1;
          if (iter_q == ITER_LAST) begin
            state_q <= VETCR_DONE;
          end
        end
        VETCR_DONE: state_q <= VETCR_IDLE;
        default: state_q <= VETCR_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      done_q <= 1'b0;
      cos_q <= FRAC_RESET;
      sin_q <= FRAC_RESET;
    end else begin
      done_q <= (state_q == VETCR_DONE);
      if (state_q == VETCR_DONE) begin
        cos_q <= sat_q15(map_x);
        sin_q <= sat_q15(map_y);
      end
    end
  end

  assign busy = (state_q != VETCR_IDLE);
  assign done = done_q;
  assign cos_out = cos_q;
  assign sin_out = sin_q;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  a_done_latency: assert property (@(posedge clk) disable iff (!reset_n) take_start |-> ##18 done)
    else $error("sine/cosine result not ready 18 cycles after start");
  a_zero_angle: assert property (@(posedge clk) disable iff (!reset_n)
    (take_start && angle == 16'h0000) |-> ##18 ($signed(cos_out) > 16'sh7f00 && $signed(sin_out) < 16'sh0010
    && $signed(sin_out) > -16'sh0010))
    else $error("angle zero did not give cosine near one and sine near zero");
endmodule

// File: tb/vetcr_regs_test.sv
`timescale 1ns/1ps
module vetcr_regs_test;
  import vetcr_pkg::*;

  // ----------------------------------------
  // Clock, reset and design hookup
  // ----------------------------------------
  localparam real PI = 3.14159265358979;

  typedef struct {
    logic [15:0] v;
    int tol;
  } vetcr_tb_note_s;

  logic clk;
  logic reset_n;
  logic [7:0] reg_addr;
  logic [31:0] reg_wdata;
  logic reg_wr;
  logic reg_rd;
  logic [31:0] reg_rdata;
  logic trig_go;
  logic [15:0] trig_angle;
  logic trig_busy;
  logic trig_updated;
  logic [15:0] prior_x_component;
  logic [15:0] prior_y_component;
  logic [15:0] current_x_component;
  logic [15:0] current_y_component;
  logic [15:0] direct_current_setpoint;
  logic [15:0] quadrature_current_setpoint;
  int fails = 0;
  int n_checks = 0;
  logic rd_d1 = 1'b0;
  vetcr_tb_note_s notes[$];
  vetcr_tb_note_s note;
  logic [15:0] model [6];
  logic [7:0] offs [6] = '{OFF_ANGLE_X, OFF_ANGLE_Y, OFF_PRIOR_X, OFF_PRIOR_Y, OFF_DIRECT_SET, OFF_QUAD_SET};
  logic [15:0] angles [8];

  vetcr_regs i_vetcr_regs (.clk(clk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .trig_go(trig_go), .trig_angle(trig_angle),
    .trig_busy(trig_busy), .trig_updated(trig_updated), .prior_x_component(prior_x_component),
    .prior_y_component(prior_y_component), .current_x_component(current_x_component),
    .current_y_component(current_y_component), .direct_current_setpoint(direct_current_setpoint),
    .quadrature_current_setpoint(quadrature_current_setpoint));

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // ----------------------------------------
  // Comparison helpers
  // ----------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Engine result is approximate; a value within tol counts as the ideal one
  function automatic logic [15:0] near(input logic [15:0] seen, input logic [15:0] exp, input int tol);
    int d;
    d = int'($signed(seen)) - int'($signed(exp));
    if (^seen === 1'bx || d > tol || d < -tol) return exp;
    return seen;
  endfunction

  function automatic logic [15:0] ideal(input real v);
    int i;
    i = $rtoi(v * 32768.0 + ((v < 0.0) ? -0.5 : 0.5));
    if (i > 32767) i = 32767;
    if (i < -32768) i = -32768;
    return i[15:0];
  endfunction

  function automatic logic [15:0] outs(input int i);
    case (i)
      0: return current_x_component;
      1: return current_y_component;
      2: return prior_x_component;
      3: return prior_y_component;
      4: return direct_current_setpoint;
      default: return quadrature_current_setpoint;
    endcase
  endfunction

  task report_and_stop;
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  // ----------------------------------------
  // Register bus driver and read monitor
  // ----------------------------------------
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [15:0] exp, input int tol);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    notes.push_back('{exp, tol});
    @(posedge clk);
    reg_rd <= 1'b0;
  endtask

  task automatic check_all(input int tol);
    for (int i = 0; i < 6; i++) begin
      check(32'(outs(i)), 32'(near(outs(i), model[i], (i < 2) ? tol : 0)));
      rd(offs[i], model[i], (i < 2) ? tol : 0);
    end
  endtask

  always @(posedge clk) begin
    if (rd_d1) begin
      if (notes.size() == 0) begin
        note = '{16'h0000, 0};
      end else begin
        note = notes.pop_front();
      end
      check(reg_rdata, {16'h0000, near(reg_rdata[15:0], note.v, note.tol)});
    end else if (reset_n) begin
      check(reg_rdata, 32'h0000_0000);
    end
    rd_d1 <= reg_rd;
  end

  // ----------------------------------------
  // Sine/cosine task driver
  // ----------------------------------------
  task automatic trig(input logic [15:0] ang);
    logic [15:0] ex;
    logic [15:0] ey;
    logic [15:0] ox;
    logic [15:0] oy;
    ox = model[IDX_X];
    oy = model[IDX_Y];
    ex = ideal($cos(2.0 * PI * real'(ang) / 65536.0));
    ey = ideal($sin(2.0 * PI * real'(ang) / 65536.0));
    @(posedge clk);
    trig_go <= 1'b1;
    trig_angle <= ang;
    @(posedge clk);
    trig_go <= 1'b0;
    for (int k = 1; k <= 19; k++) begin
      @(posedge clk);
      // A start while busy must be dropped, not queued
      if (k == 2) begin
        trig_go <= 1'b1;
        trig_angle <= ~ang;
      end
      if (k == 3) trig_go <= 1'b0;
      check(32'(trig_busy), 32'(k <= 17));
      check(32'(trig_updated), 32'(k == 19));
      if (k < 19) check(32'(current_y_component), 32'(oy));
    end
    check(32'(prior_x_component), 32'(ox));
    check(32'(prior_y_component), 32'(oy));
    check(32'(current_x_component), 32'(near(current_x_component, ex, 6)));
    check(32'(current_y_component), 32'(near(current_y_component, ey, 6)));
    model[IDX_PX] = ox;
    model[IDX_PY] = oy;
    model[IDX_X] = ex;
    model[IDX_Y] = ey;
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    logic [31:0] v;
    reset_n = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 32'h0000_0000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    trig_go = 1'b0;
    trig_angle = 16'h0000;
    void'($urandom(32'h004e4b68));
    repeat (12) @(posedge clk);
    reset_n <= 1'b1;
    for (int i = 0; i < 6; i++) model[i] = 16'h0000;
    check_all(0);
    // Random upper halves must be dropped
    for (int i = 0; i < 6; i++) begin
      v = $urandom;
      wr(offs[i], v);
      model[i] = v[15:0];
    end
    check_all(0);
    // Unmapped and unaligned places neither store nor alias
    wr(8'h18, $urandom);
    wr(8'h02, $urandom);
    rd(8'h18, 16'h0000, 0);
    rd(8'h02, 16'h0000, 0);
    check_all(0);
    angles = '{16'h0000, 16'h4000, 16'h8000, 16'hc000, 16'h2000, 16'h0000, 16'h0000, 16'h0000};
    for (int j = 5; j < 8; j++) angles[j] = 16'($urandom);
    for (int j = 0; j < 8; j++) begin
      v = $urandom;
      wr(OFF_ANGLE_X, v);
      model[IDX_X] = v[15:0];
      v = $urandom;
      wr(OFF_ANGLE_Y, v);
      model[IDX_Y] = v[15:0];
      trig(angles[j]);
      check_all(6);
    end
    repeat (3) @(posedge clk);
    check(32'(notes.size()), 32'h0000_0000);
    report_and_stop;
  end

  initial begin
    repeat (6000) @(posedge clk);
    fails++;
    report_and_stop;
  end
endmodule
